// ===== kpi_pkg.sv
// kpi_pkg: shared constants and carrier types for the keypad pin interrupt block
// assumes a 32-bit axi4-lite register bus with byte addresses below 0x100
package kpi_pkg;

  // geometry and bus widths
  localparam int unsigned KPI_PINS = 8;
  localparam int unsigned KPI_AW = 8;
  localparam int unsigned KPI_DW = 32;

  // register byte offsets
  localparam logic [7:0] OFF_SC = 8'h00;
  localparam logic [7:0] OFF_EN = 8'h04;
  localparam logic [7:0] OFF_BRK = 8'h08;
  localparam logic [7:0] OFF_EVT = 8'h0c;
  localparam logic [7:0] OFF_EVM = 8'h10;

  // field positions of kbd_status_control
  localparam int unsigned SC_MODE = 0;
  localparam int unsigned SC_MASK = 1;
  localparam int unsigned SC_ACK = 2;
  localparam int unsigned SC_FLAG = 3;

  // field positions of the break control and event registers
  localparam int unsigned BRK_BREAK_CLEAR_ENABLE = 0;
  localparam int unsigned EVT_SET = 0;
  localparam int unsigned EVT_CLR = 1;
  localparam int unsigned EVT_BITS = 2;

  // reset values
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [1:0] RST_EVT = 2'h0;
  localparam logic [1:0] RST_EVM = 2'h0;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // software control bits
  typedef struct packed {
    logic break_clear_enable;
    logic mask;
    logic mode;
  } kpi_ctrl_type;

  localparam kpi_ctrl_type RST_CTRL = '{break_clear_enable: 1'b0, mask: 1'b0, mode: 1'b0};

  // pad controls driven toward the port
  typedef struct packed {
    logic [KPI_PINS-1:0] pullup_en;
    logic [KPI_PINS-1:0] force_input;
  } kpi_pad_type;

  // one-cycle block events
  typedef struct packed {
    logic clr;
    logic set;
  } kpi_evt_type;

endpackage

// ===== kpi_sync.sv
// kpi_sync: two-flop synchroniser for a bus of independent level inputs
// assumes each bit is a slow level; multi-bit words are not kept coherent
`timescale 1ns/100ps
module kpi_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // pins idle high, so reset to ones to avoid a fake falling edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // kpi_sync

// ===== kpi_top.sv
// kpi_top: eight-pin keypad interrupt latch with an axi4-lite register slave
// assumes pins are asynchronous, vector fetch and break state are on aclk
// Behaviour
// - enabling a pin may latch a spurious request
// - unmasked request wakes processor from wait
// - unmasked request wakes processor from stop
// - break clear enabled: acknowledge clears latch
// - break clear disabled: acknowledge ignored in break
// - status register bits 7-4 read zero
// - pending flag shows latch, reset clears
// - acknowledge write clears request, reads zero
// - mask bit blocks request to processor
// - mode bit selects edge or edge-and-level
// - per-pin enable bits, reset clears all
// - latch on low after all enabled high
// - level mode clears after ack and all high
// - edge mode ack or fetch clears at once
// - enable turns on pull-up, forces input
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module kpi_top
  import kpi_pkg::*;
#(
  parameter int unsigned NUM_PINS = KPI_PINS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [KPI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [KPI_DW-1:0] s_axi_wdata,
  input wire logic [KPI_DW/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [KPI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [KPI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port pins and pad control
  input wire logic [NUM_PINS-1:0] port_a_pin,
  output kpi_pad_type pad_ctrl,
  // processor side
  input wire logic vector_fetch,
  input wire logic break_active,
  output logic kbd_cpu_req,
  output logic irq
);

  // the register layout has room for eight pins only
  if (NUM_PINS < 1 || NUM_PINS > KPI_PINS)
  begin : g_bad_pins
    $error("kpi_top: NUM_PINS must be 1 to 8");
  end

  // synchronised pins
  logic [NUM_PINS-1:0] pin_s;

  kpi_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_i(port_a_pin),
    .sync_o(pin_s)
  );

  // register state
  kpi_ctrl_type ctrl_q, ctrl_d;
  logic [NUM_PINS-1:0] pin_irq_enable_bits_q, pin_irq_enable_bits_d;
  logic [EVT_BITS-1:0] evt_q, evt_d;
  logic [EVT_BITS-1:0] evm_q, evm_d;

  // latch state
  logic latch_q, latch_d;
  logic ack_seen_q, ack_seen_d;
  logic any_low_q, any_low_d;

  // bus state
  logic [KPI_AW-1:0] awaddr_q, awaddr_d;
  logic aw_full_q, aw_full_d;
  logic [KPI_DW-1:0] wdata_q, wdata_d;
  logic w_full_q, w_full_d;
  logic w_lane0_q, w_lane0_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [KPI_DW-1:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic rd_sc_q, rd_sc_d;

  // decoded strobes
  logic do_wr, do_rd, any_low, fall_set, kbd_irq_ack, sw_ack_wr;
  kpi_evt_type evt;

  // true when the word offset is one the block decodes
  function automatic logic addr_ok(input logic [KPI_AW-1:0] a);
    return a == OFF_SC || a == OFF_EN || a == OFF_BRK || a == OFF_EVT || a == OFF_EVM;
  endfunction

  // word-aligned offset, so byte address bits 1:0 are ignored
  function automatic logic [KPI_AW-1:0] word_of(input logic [KPI_AW-1:0] a);
    return {a[KPI_AW-1:2], 2'b00};
  endfunction

  // handshake outputs
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign do_wr = aw_full_q && w_full_q && !bvalid_q;
  assign do_rd = s_axi_arvalid && !rvalid_q;

  // registered bus answers
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // write channel capture; address and data may come in either order
  always_comb
  begin
    awaddr_d = awaddr_q;
    aw_full_d = aw_full_q;
    wdata_d = wdata_q;
    w_full_d = w_full_q;
    w_lane0_d = w_lane0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awaddr_d = word_of(s_axi_awaddr);
      aw_full_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wdata_d = s_axi_wdata;
      w_lane0_d = s_axi_wstrb[0];
      w_full_d = 1'b1;
    end
    if (do_wr)
    begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
  end

  // a read answers one cycle after the address is taken
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rd_sc_d = rd_sc_q;
    if (do_rd)
    begin
      rvalid_d = 1'b1;
      rresp_d = addr_ok(word_of(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
      rd_sc_d = word_of(s_axi_araddr) == OFF_SC;
      rdata_d = '0;
      unique case (word_of(s_axi_araddr))
        OFF_SC:
        begin
          // upper nibble and the acknowledge bit stay zero
          rdata_d[SC_FLAG] = latch_q;
          rdata_d[SC_MASK] = ctrl_q.mask;
          rdata_d[SC_MODE] = ctrl_q.mode;
        end
        OFF_EN: rdata_d[NUM_PINS-1:0] = pin_irq_enable_bits_q;
        OFF_BRK: rdata_d[BRK_BREAK_CLEAR_ENABLE] = ctrl_q.break_clear_enable;
        OFF_EVT: rdata_d[EVT_BITS-1:0] = evt_q;
        OFF_EVM: rdata_d[EVT_BITS-1:0] = evm_q;
        default: rdata_d = '0;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_q <= '0;
      aw_full_q <= 1'b0;
      wdata_q <= '0;
      w_full_q <= 1'b0;
      w_lane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      rd_sc_q <= 1'b0;
    end
    else
    begin
      awaddr_q <= awaddr_d;
      aw_full_q <= aw_full_d;
      wdata_q <= wdata_d;
      w_full_q <= w_full_d;
      w_lane0_q <= w_lane0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      rd_sc_q <= rd_sc_d;
    end
  end

  // control registers; only byte lane 0 carries fields
  always_comb
  begin
    ctrl_d = ctrl_q;
    pin_irq_enable_bits_d = pin_irq_enable_bits_q;
    evm_d = evm_q;
    if (do_wr && w_lane0_q)
    begin
      unique case (awaddr_q)
        OFF_SC:
        begin
          ctrl_d.mask = wdata_q[SC_MASK];
          ctrl_d.mode = wdata_q[SC_MODE];
        end
        OFF_EN: pin_irq_enable_bits_d = wdata_q[NUM_PINS-1:0];
        OFF_BRK: ctrl_d.break_clear_enable = wdata_q[BRK_BREAK_CLEAR_ENABLE];
        OFF_EVM: evm_d = wdata_q[EVT_BITS-1:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= RST_CTRL;
      pin_irq_enable_bits_q <= RST_EN[NUM_PINS-1:0];
      evm_q <= RST_EVM;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      pin_irq_enable_bits_q <= pin_irq_enable_bits_d;
      evm_q <= evm_d;
    end
  end

  // enabled pins get a pull-up and are forced to input
  // a narrower pin count leaves the upper pads without pull-up or override
  assign pad_ctrl.pullup_en = KPI_PINS'(pin_irq_enable_bits_q);
  assign pad_ctrl.force_input = KPI_PINS'(pin_irq_enable_bits_q);

  // a freshly enabled pin that is still low looks like a falling edge
  assign any_low = |(~pin_s & pin_irq_enable_bits_q);
  assign fall_set = any_low && !any_low_q;

  // software acknowledge is dropped in break unless break clear is enabled
  assign sw_ack_wr = do_wr && w_lane0_q && awaddr_q == OFF_SC && wdata_q[SC_ACK];
  assign kbd_irq_ack = vector_fetch || (sw_ack_wr && (!break_active || ctrl_q.break_clear_enable));

  // latch: a new edge always wins over a clear in the same cycle
  always_comb
  begin
    any_low_d = any_low;
    latch_d = latch_q;
    ack_seen_d = 1'b0;
    if (fall_set)
    begin
      latch_d = 1'b1;
    end
    else if (!ctrl_q.mode)
    begin
      if (kbd_irq_ack)
      begin
        latch_d = 1'b0;
      end
    end
    else if ((kbd_irq_ack || ack_seen_q) && !any_low)
    begin
      latch_d = 1'b0;
    end
    else
    begin
      // remember the acknowledge while a pin is still held low
      ack_seen_d = latch_q && (kbd_irq_ack || ack_seen_q);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      latch_q <= 1'b0;
      ack_seen_q <= 1'b0;
      any_low_q <= 1'b0;
    end
    else
    begin
      latch_q <= latch_d;
      ack_seen_q <= ack_seen_d;
      any_low_q <= any_low_d;
    end
  end

  // the request runs in wait and stop alike, so it doubles as wake-up
  assign kbd_cpu_req = latch_q && !ctrl_q.mask;

  // sticky events cleared by reading; a new event beats the read
  assign evt.set = latch_d && !latch_q;
  assign evt.clr = latch_q && !latch_d;

  always_comb
  begin
    evt_d = evt_q;
    if (do_rd && word_of(s_axi_araddr) == OFF_EVT)
    begin
      evt_d = '0;
    end
    evt_d[EVT_SET] = evt_d[EVT_SET] | evt.set;
    evt_d[EVT_CLR] = evt_d[EVT_CLR] | evt.clr;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      evt_q <= RST_EVT;
    end
    else
    begin
      evt_q <= evt_d;
    end
  end

  assign irq = |(evt_q & evm_q);

  // falling after all enabled pins were high must latch
  edge_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!any_low_q && any_low) |=> latch_q)
    else $error("request not latched on first falling pin");

  // edge mode ignores a fall while another pin is low
  edge_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!latch_q && any_low_q && any_low) |=> !latch_q)
    else $error("request latched while a pin was already low");

  // edge mode acknowledge clears at once
  edge_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_q.mode && latch_q && vector_fetch && !fall_set) |=> !latch_q)
    else $error("edge mode fetch did not clear request");

  // level mode holds while any enabled pin is low
  level_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q.mode && latch_q && any_low) |=> latch_q)
    else $error("level request cleared while pin low");

  // break protection keeps the latch
  break_protect_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (break_active && !ctrl_q.break_clear_enable && sw_ack_wr && !vector_fetch && latch_q)
    |=> latch_q)
    else $error("acknowledge in protected break cleared latch");

  // break clear enabled lets an edge mode acknowledge through
  break_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (break_active && ctrl_q.break_clear_enable && sw_ack_wr && !ctrl_q.mode && !fall_set)
    |=> !latch_q)
    else $error("acknowledge in break did not clear latch");

  // upper status bits always read zero
  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid_q && rd_sc_q) |-> (rdata_q[7:4] == 4'h0 && !rdata_q[SC_ACK]))
    else $error("status register reserved bits not zero");

  // an unmasked new request reaches the processor next cycle
  wake_request_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (fall_set && !ctrl_q.mask && !ctrl_d.mask) |=> kbd_cpu_req)
    else $error("unmasked request did not reach processor");

  // reset clears latch, mode, mask and enables
  reset_clear_a: assert property (@(posedge aclk)
    !aresetn |=> (!latch_q && !ctrl_q.mode && !ctrl_q.mask && pin_irq_enable_bits_q == '0))
    else $error("reset left block state set");

endmodule // kpi_top

// ===== kpi_keypad.sv
// kpi_keypad: behavioural keypad switches on the port pins
// assumes the pull-up control comes from the block's pad outputs
`timescale 1ns/100ps
module kpi_keypad #(
  parameter int unsigned RISE = 4
) (
  // clock
  input wire logic aclk,
  // pad control and user actions
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] press,
  input wire logic preset_hi,
  // pin levels
  output logic [7:0] pins
);
  int unsigned rise_cnt [8];
  logic [7:0] float_q = 8'h55;

  // the pull-up needs RISE cycles to charge the pin, so enabling reads low first
  always @(posedge aclk)
  begin
    float_q <= ~float_q;
    for (int i = 0; i < 8; i++)
      rise_cnt[i] <= !pullup_en[i] ? 0 : (rise_cnt[i] < RISE ? rise_cnt[i] + 1 : RISE);
  end

  // a pressed key wins; a pin preset high stays high; an undriven pin wanders
  always_comb
    for (int i = 0; i < 8; i++)
      if (press[i])
        pins[i] = 1'b0;
      else if (preset_hi || (pullup_en[i] && rise_cnt[i] >= RISE))
        pins[i] = 1'b1;
      else
        pins[i] = pullup_en[i] ? 1'b0 : float_q[i];
endmodule // kpi_keypad

// ===== kpi_top_tb.sv
// kpi_top_tb: self-checking bench for the keypad interrupt block
// assumes the axi4-lite slave answers within a few cycles
`timescale 1ns/100ps
module kpi_top_tb;
  import kpi_pkg::*;
  localparam int unsigned RISE = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [2:0] prot = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, kbd_cpu_req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pins;
  logic [7:0] press = 8'h00;
  logic preset_hi = 1'b0, vector_fetch = 1'b0, break_active = 1'b0;
  kpi_pad_type pad_ctrl;
  logic [33:0] expq [$];
  int mismatches = 0;
  int n_compared = 0;

  always #50 aclk = ~aclk;

  kpi_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(prot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(prot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_a_pin(pins), .pad_ctrl(pad_ctrl),
    .vector_fetch(vector_fetch), .break_active(break_active), .kbd_cpu_req(kbd_cpu_req),
    .irq(irq));

  kpi_keypad #(.RISE(RISE)) keys (.aclk(aclk), .pullup_en(pad_ctrl.pullup_en),
    .press(press), .preset_hi(preset_hi), .pins(pins));

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d, compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // one write; the response is noted for the monitor before the request goes out
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    expq.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    prot <= 3'($urandom);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    check(34'(n < 40), 34'h1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // one read with its expected word noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    expq.push_back({r, d});
    araddr <= a;
    prot <= 3'($urandom);
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    check(34'(n < 40), 34'h1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // monitor: every response taken off the bus is matched against the oldest note
  always @(posedge aclk)
  begin
    if (bvalid && bready) check({bresp, 32'h0}, expq.pop_front());
    if (rvalid && rready) check({rresp, rdata}, expq.pop_front());
  end

  initial
  begin
    #500000;
    mismatches++;
    stop_test();
  end

  initial
  begin
    logic [7:0] v;
    void'($urandom(14));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_SC, 32'h0, RESP_OKAY);
    rd(OFF_EN, 32'h0, RESP_OKAY);
    rd(OFF_BRK, 32'h0, RESP_OKAY);
    rd(OFF_EVT, 32'h0, RESP_OKAY);
    rd(OFF_EVM, 32'h0, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'hff, RESP_SLVERR);
    check(34'(pad_ctrl), 34'h0);
    done("reset values");
    // pins preset high before enabling give no request
    preset_hi <= 1'b1;
    wr(OFF_EN, 32'hf0, RESP_OKAY);
    idle(8);
    rd(OFF_SC, 32'h0, RESP_OKAY);
    preset_hi <= 1'b0;
    done("preset init");
    // masked init: spurious latch from slow pull-ups is acknowledged away
    wr(OFF_SC, 32'h02, RESP_OKAY);
    wr(OFF_EN, 32'h0f, RESP_OKAY);
    idle(RISE + 6);
    check(34'(pad_ctrl), 34'h0f0f);
    rd(OFF_SC, 32'h0a, RESP_OKAY);
    check(34'(kbd_cpu_req), 34'h0);
    wr(OFF_SC, 32'h06, RESP_OKAY);
    rd(OFF_SC, 32'h02, RESP_OKAY);
    wr(OFF_SC, 32'h00, RESP_OKAY);
    rd(OFF_EVT, 32'h3, RESP_OKAY);
    rd(OFF_EVT, 32'h0, RESP_OKAY);
    done("masked init");
    // edge mode: latch, wake request, ack while low, blocked second edge
    wr(OFF_EVM, 32'h1, RESP_OKAY);
    press <= 8'h01;
    idle(8);
    check(34'(kbd_cpu_req), 34'h1);
    check(34'(irq), 34'h1);
    rd(OFF_SC, 32'h08, RESP_OKAY);
    wr(OFF_SC, 32'h04, RESP_OKAY);
    rd(OFF_SC, 32'h00, RESP_OKAY);
    press <= 8'h03;
    idle(8);
    rd(OFF_SC, 32'h00, RESP_OKAY);
    press <= 8'h10;
    idle(8);
    rd(OFF_SC, 32'h00, RESP_OKAY);
    press <= 8'h04;
    idle(8);
    wr(OFF_SC, 32'h02, RESP_OKAY);
    check(34'(kbd_cpu_req), 34'h0);
    rd(OFF_SC, 32'h0a, RESP_OKAY);
    vector_fetch <= 1'b1;
    @(posedge aclk);
    vector_fetch <= 1'b0;
    idle(2);
    rd(OFF_SC, 32'h02, RESP_OKAY);
    rd(OFF_EVT, 32'h3, RESP_OKAY);
    idle(2);
    check(34'(irq), 34'h0);
    wr(OFF_SC, 32'h00, RESP_OKAY);
    press <= 8'h00;
    done("edge mode");
    // level mode: ack is held until every enabled pin is high again
    wr(OFF_SC, 32'h01, RESP_OKAY);
    press <= 8'h08;
    idle(8);
    wr(OFF_SC, 32'h05, RESP_OKAY);
    rd(OFF_SC, 32'h09, RESP_OKAY);
    press <= 8'h00;
    idle(8);
    rd(OFF_SC, 32'h01, RESP_OKAY);
    done("level mode");
    // break state: ack ignored until break clear is enabled
    wr(OFF_SC, 32'h00, RESP_OKAY);
    press <= 8'h01;
    idle(8);
    press <= 8'h00;
    break_active <= 1'b1;
    wr(OFF_SC, 32'h04, RESP_OKAY);
    rd(OFF_SC, 32'h08, RESP_OKAY);
    wr(OFF_BRK, 32'h1, RESP_OKAY);
    rd(OFF_BRK, 32'h1, RESP_OKAY);
    wr(OFF_SC, 32'h04, RESP_OKAY);
    break_active <= 1'b0;
    idle(2);
    rd(OFF_SC, 32'h00, RESP_OKAY);
    done("break state");
    // random enable patterns read back and reach the pads
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      wr(OFF_EN, {24'h0, v}, RESP_OKAY);
      rd(OFF_EN, {24'h0, v}, RESP_OKAY);
      check(34'(pad_ctrl), {18'h0, v, v});
    end
    done("random enables");
    stop_test();
  end
endmodule // kpi_top_tb
